// file: rtl/sdim_top.sv
// SD host interrupt masking, stop-command status and capabilities
`timescale 1ns/10ps

// Functional notes
// - ADMA error flag sets only while flag-enable bit 25 is one.
// - Stop-command error flag sets only while flag-enable bit 24 is one.
// - Bits 23..20 gate current-limit, data end-bit, CRC, time-out flags.
// - Bits 19..16 gate command index, end-bit, CRC, time-out flags.
// - Card interrupt flag gated by bit 8, which is read-only zero.
// - Bit 7 gates card removal, bit 6 gates card insertion.
// - Bit 5 gates buffer-read-ready, bit 4 gates buffer-write-ready.
// - Bits 3..0 gate DMA, block-gap, transfer-done, command-done flags.
// - Flag-enable bit 15 is read-only zero.
// - Signal-enable bits 25..16 gate each error onto the interrupt.
// - Signal enables bits 8..0 for events; bits 7..0 reset to one.
// - Bits 31..26 and 14..9 of both enables read zero, ignore writes.
// - Stop status bit 7 shows a command not issued by stop error.
// - Stop status bit 4 shows a stop-command index error.
// - Stop status bit 3 shows a stop-command end-bit error.
// - Stop status bit 2 shows a stop-command response CRC error.
// - Stop status bit 1 shows a stop-command response time-out.
// - Stop status bit 0 set when not executed, clear when executed.
// - Stop status is read-only, hardware cleared, reset zero, gaps zero.
// - Capability field reports maximum block length, 11 reserved.
// - Error summary bit 15 set while any error flag is set.
module sdim_top
    import sdim_pkg::*;
#(
    parameter bit CAP_SRESUME = 1'b0,
    parameter bit CAP_HISPEED = 1'b1,
    parameter bit CAP_ADMA2 = 1'b1,
    parameter logic [1:0] CAP_MAX_BLOCK_LEN = 2'h0,
    parameter logic [5:0] CAP_BASECLK = 6'h32,
    parameter bit CAP_TOCLK_KHZ = 1'b0,
    parameter logic [5:0] CAP_TOCLK_FREQ = 6'h01
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Event pulses from the command and data engines
    input wire logic [31:0] evt_set,
    input wire sdim_stopcmd_t stopcmd_in,
    // Interrupt to the system
    output logic irq
);

    // ****************************************************************
    // Bus front end
    // ****************************************************************
    sdim_bus_state_t state_r;
    sdim_bus_state_t state_nxt;
    logic [7:0] addr_r;
    logic [31:0] flag_en_r;
    logic [31:0] sig_en_r;
    logic [31:0] stat_r;
    logic [31:0] stopcmd_r;
    logic [31:0] caps;
    logic [31:0] stat_view;
    logic [31:0] rd_val;
    logic [31:0] hrdata_r;
    logic take;
    logic wr_now;
    logic [31:0] stat_clr;
    logic [31:0] stat_set;

    assign take = hsel & htrans[1] & hready;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE, ST_WRITE, ST_RD_DATA: begin
                if (take) begin
                    state_nxt = hwrite ? ST_WRITE : ST_RD_WAIT;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RD_WAIT: begin
                state_nxt = ST_RD_DATA;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 8'h00;
        end else if (take) begin
            addr_r <= {haddr[7:2], 2'h0};
        end
    end

    // One wait state on reads so a write just before is always seen
    assign hreadyout = (state_r != ST_RD_WAIT);
    assign hresp = 1'b0;
    assign wr_now = (state_r == ST_WRITE);

    // ****************************************************************
    // Enable registers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_en_r <= FLAG_EN_RST;
        end else if (wr_now && addr_r == OFS_FLAG_EN) begin
            flag_en_r <= hwdata & FLAG_EN_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sig_en_r <= SIG_EN_RST;
        end else if (wr_now && addr_r == OFS_SIG_EN) begin
            sig_en_r <= hwdata & SIG_EN_WMASK;
        end
    end

    // ****************************************************************
    // Interrupt status flags
    // ****************************************************************
    // Write one to clear; an event in the same cycle wins the clear
    assign stat_clr = (wr_now && addr_r == OFS_INT_STAT) ? hwdata : 32'h0;
    // Flag enable gates the setting, never clears a flag already set
    assign stat_set = evt_set & flag_en_r
                    & STAT_MASK;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= STAT_RST;
        end else begin
            stat_r <= ((stat_r & ~stat_clr) | stat_set) & STAT_MASK;
        end
    end

    always_comb begin
        stat_view = stat_r;
        stat_view[BIT_SUMMARY] = |(stat_r & ERR_MASK);
    end

    // Both enables must be set for a flag to reach the interrupt line
    assign irq = |(stat_r & flag_en_r & sig_en_r);

    // ****************************************************************
    // Stop-command status, follows the command engine
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stopcmd_r <= STOPCMD_RST;
        end else begin
            stopcmd_r <= {24'h0, stopcmd_in.cmd_not_issued_err, 2'h0,
                          stopcmd_in.stopcmd_index_err,
                          stopcmd_in.stopcmd_endbit_err,
                          stopcmd_in.stopcmd_crc_err,
                          stopcmd_in.stopcmd_timeout_err,
                          stopcmd_in.stopcmd_not_run};
        end
    end

    // ****************************************************************
    // Capabilities, fixed at build time
    // ****************************************************************
    always_comb begin
        caps = 32'h0;
        caps[CAP_VOLT_BIT] = 1'b1;
        caps[CAP_SRESUME_BIT] = CAP_SRESUME;
        caps[CAP_HISPEED_BIT] = CAP_HISPEED;
        caps[CAP_ADMA2_BIT] = CAP_ADMA2;
        caps[CAP_MAX_BLOCK_LEN_LSB +: 2] = CAP_MAX_BLOCK_LEN;
        caps[CAP_BASECLK_LSB +: 6] = CAP_BASECLK;
        caps[CAP_TOCLKU_BIT] = CAP_TOCLK_KHZ;
        caps[5:0] = CAP_TOCLK_FREQ;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        unique case (addr_r)
            OFS_FLAG_EN: rd_val = flag_en_r;
            OFS_SIG_EN: rd_val = sig_en_r;
            OFS_INT_STAT: rd_val = stat_view;
            OFS_STOPCMD: rd_val = stopcmd_r & STOPCMD_MASK;
            OFS_CAPS: rd_val = caps;
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0;
        end else if (state_r == ST_RD_WAIT) begin
            hrdata_r <= rd_val;
        end
    end

    assign hrdata = hrdata_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_adma_mask: assert property (
        (!flag_en_r[BIT_ADMA_ERR] && !stat_r[BIT_ADMA_ERR])
        |=> !stat_r[BIT_ADMA_ERR])
        else $error("ADMA error flag set while masked");

    a_stopcmd_mask: assert property (
        (!flag_en_r[BIT_STOPCMD_ERR] && !stat_r[BIT_STOPCMD_ERR])
        |=> !stat_r[BIT_STOPCMD_ERR])
        else $error("Stop-command error flag set while masked");

    a_data_err_set: assert property (
        (evt_set[20] && flag_en_r[20]) |=> stat_r[20])
        else $error("Data time-out flag not set");

    a_cmd_err_set: assert property (
        (evt_set[16] && flag_en_r[16]) |=> stat_r[16] && stat_view[15])
        else $error("Command time-out flag or summary not set");

    a_card_held: assert property (
        !stat_r[BIT_CARD_IRQ] && !flag_en_r[BIT_CARD_IRQ])
        else $error("Card interrupt flag not masked");

    a_insert_set: assert property (
        (evt_set[6] && flag_en_r[6]) |=> stat_r[6])
        else $error("Card insertion flag not set");

    a_rdbuf_mask: assert property (
        (evt_set[5] && !flag_en_r[5] && !stat_r[5]) |=> !stat_r[5])
        else $error("Read-ready flag set while masked");

    a_done_set: assert property (
        (evt_set[0] && flag_en_r[0]) |=> stat_r[0])
        else $error("Command-done flag not set");

    a_enable_gaps: assert property (
        (flag_en_r & ~FLAG_EN_WMASK) == 32'h0
        && (sig_en_r & ~SIG_EN_WMASK) == 32'h0)
        else $error("Reserved enable bit set");

    a_summary_bit: assert property (
        stat_view[BIT_SUMMARY] == |stat_r[25:16])
        else $error("Error summary mismatch");

    a_irq_gate: assert property (
        (stat_r[0] && flag_en_r[0] && sig_en_r[0]) |-> irq)
        else $error("Interrupt missing for enabled flag");

    a_flag_holds: assert property (
        (stat_r[3] && !stat_clr[3]) |=> stat_r[3])
        else $error("Flag lost without a clear");

    a_stopcmd_track: assert property (
        ##1 stopcmd_r[0] == $past(stopcmd_in.stopcmd_not_run))
        else $error("Stop-command status does not follow");

    a_read_wait: assert property (
        (take && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("Read wait state wrong");

    // Spot checks per bit; masking and setting for the other bits match
    a_curlim_set: assert property (
        (evt_set[23] && flag_en_r[23]) |=> stat_r[23])
        else $error("Current-limit flag not set");

    a_data_crc_mask: assert property (
        (!flag_en_r[21] && !stat_r[21]) |=> !stat_r[21])
        else $error("Data CRC flag set while masked");

    a_cmd_idx_mask: assert property (
        (!flag_en_r[19] && !stat_r[19]) |=> !stat_r[19])
        else $error("Command index flag set while masked");

    a_removal_set: assert property (
        (evt_set[7] && flag_en_r[7]) |=> stat_r[7])
        else $error("Card removal flag not set");

    a_insert_mask: assert property (
        (!flag_en_r[6] && !stat_r[6]) |=> !stat_r[6])
        else $error("Card insertion flag set while masked");

    a_wrbuf_set: assert property (
        (evt_set[4] && flag_en_r[4]) |=> stat_r[4])
        else $error("Write-ready flag not set");

    a_dma_mask: assert property (
        (!flag_en_r[3] && !stat_r[3]) |=> !stat_r[3])
        else $error("DMA flag set while masked");

    a_summary_enable: assert property (
        !flag_en_r[BIT_SUMMARY] && !sig_en_r[BIT_SUMMARY])
        else $error("Summary enable bit not zero");

    a_err_irq: assert property (
        (stat_r[24] && flag_en_r[24] && sig_en_r[24]) |-> irq)
        else $error("Interrupt missing for enabled error");

    a_irq_quiet: assert property (
        ((stat_r & flag_en_r & sig_en_r) == 32'h0) |-> !irq)
        else $error("Interrupt with nothing enabled");

    a_flag_en_write: assert property (
        (wr_now && addr_r == OFS_FLAG_EN)
        |=> flag_en_r == ($past(hwdata) & FLAG_EN_WMASK))
        else $error("Flag enable write wrong");

    a_sig_en_write: assert property (
        (wr_now && addr_r == OFS_SIG_EN)
        |=> sig_en_r == ($past(hwdata) & SIG_EN_WMASK))
        else $error("Signal enable write wrong");

    a_stop_not_issued: assert property (
        stopcmd_in.cmd_not_issued_err |=> stopcmd_r[7])
        else $error("Command-not-issued bit not set");

    a_stop_index: assert property (
        stopcmd_in.stopcmd_index_err |=> stopcmd_r[4])
        else $error("Stop index error bit not set");

    a_stop_endbit: assert property (
        stopcmd_in.stopcmd_endbit_err |=> stopcmd_r[3])
        else $error("Stop end-bit error bit not set");

    a_stop_crc: assert property (
        stopcmd_in.stopcmd_crc_err |=> stopcmd_r[2])
        else $error("Stop CRC error bit not set");

    a_stop_timeout: assert property (
        stopcmd_in.stopcmd_timeout_err |=> stopcmd_r[1])
        else $error("Stop time-out bit not set");

    a_stop_cleared: assert property (
        !stopcmd_in.stopcmd_not_run |=> !stopcmd_r[0])
        else $error("Not-executed bit not cleared");

    a_stop_gaps: assert property (
        (state_r == ST_RD_DATA && addr_r == OFS_STOPCMD)
        |-> (hrdata & ~STOPCMD_MASK) == 32'h0)
        else $error("Stop status gap bits not zero");

    a_max_block_len_legal: assert property (
        caps[CAP_MAX_BLOCK_LEN_LSB +: 2] != 2'h3)
        else $error("Reserved block length code");

    a_set_wins: assert property (
        stat_set[1] |=> stat_r[1])
        else $error("Event lost to a clear");

    a_clear_works: assert property (
        (stat_clr[0] && !stat_set[0]) |=> !stat_r[0])
        else $error("Flag not cleared by write");

    a_okay_resp: assert property (
        !hresp)
        else $error("Error response returned");

    c_irq_rise: cover property ($rose(irq));
    c_read_done: cover property (state_r == ST_RD_DATA);
    c_set_clear: cover property (stat_clr[1] && stat_set[1]);
    c_err_summary: cover property (stat_view[BIT_SUMMARY]);
    c_stop_error: cover property (stopcmd_r[7]);

endmodule : sdim_top

// file: rtl/sdim_pkg.sv
// Package for the SD host interrupt masking block: map, fields, types
package sdim_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_FLAG_EN = 8'h00;
    localparam logic [7:0] OFS_SIG_EN = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_STOPCMD = 8'h0C;
    localparam logic [7:0] OFS_CAPS = 8'h10;

    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int BIT_ADMA_ERR = 25;
    localparam int BIT_STOPCMD_ERR = 24;
    localparam int BIT_SUMMARY = 15;
    localparam int BIT_CARD_IRQ = 8;
    localparam logic [31:0] ERR_MASK = 32'h03FF_0000;
    localparam logic [31:0] FLAG_EN_WMASK = 32'h03FF_00FF;
    localparam logic [31:0] SIG_EN_WMASK = 32'h03FF_01FF;
    localparam logic [31:0] STAT_MASK = 32'h03FF_01FF;
    localparam logic [31:0] STOPCMD_MASK = 32'h0000_009F;
    localparam int CAP_VOLT_BIT = 24;
    localparam int CAP_SRESUME_BIT = 23;
    localparam int CAP_HISPEED_BIT = 21;
    localparam int CAP_ADMA2_BIT = 19;
    localparam int CAP_MAX_BLOCK_LEN_LSB = 16;
    localparam int CAP_BASECLK_LSB = 8;
    localparam int CAP_TOCLKU_BIT = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] FLAG_EN_RST = 32'h0000_0000;
    localparam logic [31:0] SIG_EN_RST = 32'h0000_00FF;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;
    localparam logic [31:0] STOPCMD_RST = 32'h0000_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic cmd_not_issued_err;
        logic stopcmd_index_err;
        logic stopcmd_endbit_err;
        logic stopcmd_crc_err;
        logic stopcmd_timeout_err;
        logic stopcmd_not_run;
    } sdim_stopcmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WRITE = 4'h2,
        ST_RD_WAIT = 4'h4,
        ST_RD_DATA = 4'h8
    } sdim_bus_state_t;

endpackage : sdim_pkg

// file: verif/sdim_engine_model.sv
// Stand-in for the command and data engines feeding event and stop status
`timescale 1ns/10ps
module sdim_engine_model
    import sdim_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Requests from the bench
    input wire logic [31:0] evt_req,
    input wire sdim_stopcmd_t stop_req,
    // Toward the block
    output logic [31:0] evt_set,
    output sdim_stopcmd_t stopcmd_in
);
    // Engines register their outputs, so events land one cycle late
    always_ff @(posedge hclk) begin
        evt_set <= evt_req;
        stopcmd_in <= stop_req;
    end
endmodule : sdim_engine_model

// file: verif/tb_top.sv
// Self-checking bench for the SD host interrupt masking block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top
    import sdim_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, evt_req, evt_set, exp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    sdim_stopcmd_t stop_req, stopcmd_in;
    int error_cnt = 0;
    int tests_run = 0;

    sdim_top u_sdim_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .evt_set(evt_set),
        .stopcmd_in(stopcmd_in), .irq(irq));
    sdim_engine_model u_sdim_engine_model (.hclk(hclk), .evt_req(evt_req),
        .stop_req(stop_req), .evt_set(evt_set), .stopcmd_in(stopcmd_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    // The slave sets the pace; only the watchdog ends a stuck wait
    task automatic wait_rdy();
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? wd : 32'h0;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        `CHK("hresp", 1'b0, hresp)
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        `CHK(nm, e, v)
    endtask : rchk
    // Two edges after the request the flag and irq have settled
    task automatic pulse(input logic [31:0] m);
        evt_req <= m;
        @(posedge hclk);
        evt_req <= 32'h0;
        repeat (2) @(posedge hclk);
    endtask : pulse
    task automatic ichk(input logic e);
        #1;
        `CHK("irq", e, irq)
        @(posedge hclk);
    endtask : ichk
    task automatic end_test(input string nm);
        $display("test %s done, checks %0d, wrong %0d", nm, tests_run,
                 error_cnt);
    endtask : end_test
    task automatic final_report();
        $display("checks %0d wrong %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        evt_req = 32'h0;
        stop_req = '0;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("flag_en rst", OFS_FLAG_EN, 32'h0000_0000);
        rchk("sig_en rst", OFS_SIG_EN, 32'h0000_00FF);
        rchk("stop rst", OFS_STOPCMD, 32'h0000_0000);
        rchk("caps", OFS_CAPS, 32'h0128_3201);
        rchk("unmapped", 8'h20, 32'h0000_0000);
        wr(OFS_FLAG_EN, 32'hFFFF_FFFF);
        rchk("flag_en ones", OFS_FLAG_EN, 32'h03FF_00FF);
        wr(OFS_SIG_EN, 32'hFFFF_FFFF);
        rchk("sig_en ones", OFS_SIG_EN, 32'h03FF_01FF);
        end_test("registers");
        // One enable at a time; every event fires, signals all masked
        wr(OFS_SIG_EN, 32'h0);
        for (int i = 0; i < 26; i++) begin
            wr(OFS_INT_STAT, 32'hFFFF_FFFF);
            wr(OFS_FLAG_EN, 32'h1 << i);
            pulse(32'hFFFF_FFFF);
            exp = (32'h1 << i) & FLAG_EN_WMASK;
            if ((exp & ERR_MASK) != 32'h0) exp[BIT_SUMMARY] = 1'b1;
            rchk("gate", OFS_INT_STAT, exp);
            ichk(1'b0);
        end
        wr(OFS_SIG_EN, 32'h0200_0000);
        ichk(1'b1);
        wr(OFS_FLAG_EN, 32'h0);
        rchk("kept flag", OFS_INT_STAT, 32'h0200_8000);
        ichk(1'b0);
        end_test("masking");
        for (int j = 0; j < 6; j++) begin
            stop_req <= 6'(1 << j);
            repeat (2) @(posedge hclk);
            exp = (j == 5) ? 32'h0000_0080 : (32'h1 << j);
            rchk("stop flag", OFS_STOPCMD, exp);
        end
        // A write of ones must leave the held error untouched
        wr(OFS_STOPCMD, 32'hFFFF_FFFF);
        rchk("stop ro", OFS_STOPCMD, 32'h0000_0080);
        stop_req <= '0;
        repeat (2) @(posedge hclk);
        rchk("stop clear", OFS_STOPCMD, 32'h0);
        end_test("stop status");
        final_report();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule : tb_top
